// ==== design/ledspi_port.sv ====
// Purpose: Serial command port of a dual-channel LED current controller
// Assumes: ssn/sck/mosi asynchronous to ref_clk, sck well below ref_clk/4
// Notes:   APB side gives test access to flags, counters and serial registers

`timescale 1ns/1ps

module ledspi_port #(
    parameter int FCNT_W = 16
) (
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    input  wire logic                ssn_pin,
    input  wire logic                sck_pin,
    input  wire logic                mosi_pin,
    output      logic                miso_out,
    output      logic                miso_oe,
    input  wire logic [11:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output      logic [31:0]         prdata,
    output      logic                pready,
    output      logic                pslverr
);
    import ledspi_pkg::*;

    if (FCNT_W < 1 || FCNT_W > 16) begin : g_bad_fcnt
        $error("FCNT_W must be 1..16");
    end

    // ------------------------------------------------------------
    // Pin synchronisers {ssn, sck, mosi}
    // ------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 3'h4;
            sync2 <= 3'h4;
            sync3 <= 3'h4;
        end else begin
            sync1 <= {ssn_pin, sck_pin, mosi_pin};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    wire ssn_lvl  = sync2[2];
    wire ssn_fall = !sync2[2] && sync3[2];
    wire ssn_rise = sync2[2] && !sync3[2];
    wire sck_rise = sync2[1] && !sync3[1];
    wire sck_fall = !sync2[1] && sync3[1];
    wire mosi_s   = sync2[0];

    // ------------------------------------------------------------
    // Frame state and bit counting
    // ------------------------------------------------------------
    ledspi_state_e state;
    ledspi_state_e next_state;
    logic [3:0]    bit_cnt;
    logic          any_clk;
    logic          full16;

    wire active   = (state == LEDSPI_ACTIVE);
    wire clk_in   = active && !ssn_lvl && sck_rise;
    // No output shift until a rising edge has been seen
    wire clk_out  = active && !ssn_lvl && sck_fall && any_clk;
    wire decode   = active && ssn_rise;

    always_comb begin
        case (state)
            LEDSPI_IDLE:   next_state = ssn_fall ? LEDSPI_ACTIVE : LEDSPI_IDLE;
            LEDSPI_ACTIVE: next_state = ssn_rise ? LEDSPI_IDLE : LEDSPI_ACTIVE;
            default:       next_state = LEDSPI_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state   <= LEDSPI_IDLE;
            bit_cnt <= 4'h0;
            any_clk <= 1'b0;
            full16  <= 1'b0;
        end else begin
            state <= next_state;
            if (ssn_fall) begin
                bit_cnt <= 4'h0;
                any_clk <= 1'b0;
                full16  <= 1'b0;
            end else if (clk_in) begin
                bit_cnt <= bit_cnt + 4'h1;
                any_clk <= 1'b1;
                if (bit_cnt == 4'hF) begin
                    full16 <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Shift register and frame fields
    // ------------------------------------------------------------
    logic [15:0]       shreg;
    logic [15:0]       resp;
    logic [DATA_W-1:0] mem [32];

    wire              fr_cmd   = shreg[CMD_BIT];
    wire [ADDR_W-1:0] fr_addr  = shreg[ADDR_MSB:ADDR_LSB];
    wire              fr_pbit  = shreg[PARITY_POS];
    wire [DATA_W-1:0] fr_data  = shreg[DATA_W-1:0];
    wire [DATA_W-1:0] fr_word  = mem[fr_addr];
    wire [14:0]       echo_w   = {shreg[15:10], shreg[8:0]};

    wire len_err  = !any_clk || !full16 || (bit_cnt != 4'h0);
    wire parity_err = fr_pbit != ~^{fr_cmd, fr_addr, fr_data};
    wire rd_err   = !fr_cmd && (fr_data != '0);
    wire frame_err = len_err || parity_err || rd_err;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shreg <= 16'h0000;
        end else if (ssn_fall) begin
            shreg <= resp;
        end else if (clk_in) begin
            shreg <= {shreg[14:0], mosi_s};
        end
    end

    // ------------------------------------------------------------
    // Decode, error flag and response selection
    // ------------------------------------------------------------
    logic              serial_error_flag;
    logic [3:0]        ctrl;
    logic [15:0]       last_cmd;
    logic [FCNT_W-1:0] frame_cnt;

    wire err_rep   = serial_error_flag || frame_err;
    wire stat_rd   = !fr_cmd && (fr_addr == STATUS_ADDR);
    // New error wins over the clear from a status read
    wire next_serial_error_flag = frame_err || (serial_error_flag && !stat_rd);
    wire mem_we    = decode && fr_cmd && !frame_err;

    wire [15:0] rd_resp = {err_rep, RSV_BITS, ctrl[CTRL_PWRCYC], ctrl[CTRL_CH2_UV],
                           ctrl[CTRL_CH1_UV], ctrl[CTRL_THERM], fr_word};
    wire [15:0] wr_resp = {err_rep, echo_w};
    wire [15:0] resp_nx = !fr_cmd ? rd_resp :
                          frame_err ? POR_WORD : wr_resp;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            resp      <= POR_WORD;
            serial_error_flag <= 1'b0;
            last_cmd  <= 16'h0000;
            frame_cnt <= '0;
        end else if (decode) begin
            resp      <= resp_nx;
            serial_error_flag <= next_serial_error_flag;
            last_cmd  <= shreg;
            frame_cnt <= frame_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 32; i++) begin
                mem[i] <= '0;
            end
        end else if (mem_we) begin
            mem[fr_addr] <= fr_data;
        end
    end

    // ------------------------------------------------------------
    // Open-drain output
    // ------------------------------------------------------------
    logic miso_bit;
    logic next_miso_bit;

    wire next_act = ssn_fall || (active && !ssn_rise);

    always_comb begin
        next_miso_bit = miso_bit;
        if (ssn_fall) begin
            next_miso_bit = resp[15];
        end else if (clk_out) begin
            next_miso_bit = shreg[15];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            miso_bit <= 1'b1;
            miso_oe  <= 1'b0;
            miso_out <= 1'b0;
        end else begin
            miso_bit <= next_miso_bit;
            miso_oe  <= next_act && !next_miso_bit;
            miso_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    wire apb_acc  = psel && penable && !pready;
    wire apb_done = psel && penable && pready;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_stat = (paddr == OFS_STAT);
    wire hit_fcnt = (paddr == OFS_FRAMES);
    wire hit_mem  = (paddr[11:7] == OFS_MEM[11:7]) && (paddr[1:0] == 2'h0);
    wire mapped   = hit_ctrl || hit_stat || hit_fcnt || hit_mem;

    wire [31:0] rd_ctrl = {28'h0000000, ctrl};
    wire [31:0] rd_stat = {last_cmd, 14'h0000, active, serial_error_flag};
    wire [31:0] rd_fcnt = {{(32 - FCNT_W){1'b0}}, frame_cnt};
    wire [31:0] rd_mem  = {{(32 - DATA_W){1'b0}}, mem[paddr[6:2]]};
    wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
                          hit_stat ? rd_stat :
                          hit_fcnt ? rd_fcnt :
                          hit_mem  ? rd_mem  : 32'h00000000;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            ctrl    <= CTRL_RST;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc && !mapped;
            prdata  <= (apb_acc && !pwrite) ? rd_data : 32'h00000000;
            if (apb_done && pwrite && hit_ctrl) begin
                ctrl <= pwdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    AST_IDLE_RELEASE: assert property (ssn_lvl && !ssn_fall |=> !miso_oe)
        else $error("miso driven while deselected");
    AST_FIRST_BIT: assert property (ssn_fall |=> miso_bit == $past(resp[15]))
        else $error("select fall did not present response msb");
    AST_FALL_ONLY: assert property (active && !ssn_fall && !clk_out |=> $stable(miso_bit))
        else $error("miso changed off a falling clock");
    AST_NO_EARLY: assert property (active && !any_clk |=> $stable(miso_bit))
        else $error("miso moved before first rising clock");
    AST_SHIFT_IN: assert property (clk_in |=> shreg[0] == $past(mosi_s))
        else $error("mosi bit not captured");
    AST_SHORT_ERR: assert property (decode && !full16 |=> serial_error_flag)
        else $error("short frame not flagged");
    AST_ZERO_CLK: assert property (decode && !any_clk |=> serial_error_flag && resp[15])
        else $error("clockless frame not flagged");
    AST_BAD_WRITE: assert property (decode && fr_cmd && frame_err |=> $stable(fr_word))
        else $error("errored write changed register");
    AST_POR_WORD: assert property (decode && fr_cmd && frame_err |=> resp == POR_WORD)
        else $error("errored write response wrong");
    AST_WR_ECHO: assert property (decode && fr_cmd && !frame_err
                                  |=> resp[14:0] == $past(echo_w))
        else $error("write echo wrong");
    AST_RD_FMT: assert property (decode && !fr_cmd
                                 |=> resp[14:13] == RSV_BITS
                                 && resp[15] == (serial_error_flag || $past(serial_error_flag)))
        else $error("read response format wrong");
    AST_APB_ONE: assert property (apb_acc |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    COV_READ:  cover property (decode && !fr_cmd && !frame_err);
    COV_WRITE: cover property (decode && fr_cmd && !frame_err);
    COV_ERR:   cover property (decode && frame_err);
    COV_CHAIN: cover property (decode && any_clk && full16 && bit_cnt == 4'h0 && !parity_err);

endmodule : ledspi_port

// ==== design/ledspi_pkg.sv ====
// Purpose: Shared constants for the LED driver serial command port
// Assumes: 16-bit command frames, APB register access at 32-bit words
// Notes:   Offsets are byte addresses on the APB side

package ledspi_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int          FRAME_W     = 16;
    localparam int          DATA_W      = 9;
    localparam int          ADDR_W      = 5;
    localparam int          CMD_BIT     = 15;
    localparam int          ADDR_MSB    = 14;
    localparam int          ADDR_LSB    = 10;
    localparam int          PARITY_POS  = 9;
    localparam logic [15:0] POR_WORD    = 16'h8000;
    localparam logic [1:0]  RSV_BITS    = 2'h3;
    localparam logic [4:0]  STATUS_ADDR = 5'h01;

    // ------------------------------------------------------------
    // APB map
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_STAT    = 12'h004;
    localparam logic [11:0] OFS_FRAMES  = 12'h008;
    localparam logic [11:0] OFS_MEM     = 12'h080;
    localparam int          CTRL_THERM  = 0;
    localparam int          CTRL_CH1_UV = 1;
    localparam int          CTRL_CH2_UV = 2;
    localparam int          CTRL_PWRCYC = 3;
    localparam logic [3:0]  CTRL_RST    = 4'h8;
    localparam int          STAT_SERR   = 0;
    localparam int          STAT_ACT    = 1;
    localparam int          STAT_LAST   = 16;

    typedef enum logic [0:0] {
        LEDSPI_IDLE   = 1'b0,
        LEDSPI_ACTIVE = 1'b1
    } ledspi_state_e;

endpackage : ledspi_pkg

// ==== dv/ledspi_master.sv ====
// Purpose: Serial bus master model facing the LED port
// Assumes: Link clock 160 ns, idle low; miso wire pulled up
// Notes:   Keeps only the last 16 bits sampled from the return line
`timescale 1ns/1ps

module ledspi_master (
    input  wire logic ref_clk,
    output logic      ssn_pin,
    output logic      sck_pin,
    output logic      mosi_pin,
    input  wire logic miso_w
);
    logic [15:0] rx;
    event        done_ev;

    initial begin
        ssn_pin  = 1'b1;
        sck_pin  = 1'b0;
        mosi_pin = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame transfer, n clocks, bits w[n-1] down to w[0]
    // ------------------------------------------------------------
    // Half link period is 8 ref_clk cycles, 160 ns per link clock
    task automatic xfer(input logic [31:0] w, input int n);
        @(posedge ref_clk);
        ssn_pin <= 1'b0;
        rx = 16'h0000;
        repeat (8) @(posedge ref_clk);
        for (int i = n - 1; i >= 0; i--) begin
            mosi_pin <= w[i];
            repeat (8) @(posedge ref_clk);
            sck_pin <= 1'b1;
            rx = {rx[14:0], miso_w};
            repeat (8) @(posedge ref_clk);
            sck_pin <= 1'b0;
        end
        repeat (8) @(posedge ref_clk);
        ssn_pin <= 1'b1;
        // Released data line must not keep a stale level
        mosi_pin <= ~mosi_pin;
        repeat (8) @(posedge ref_clk);
        -> done_ev;
    endtask : xfer

endmodule : ledspi_master

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the LED serial command port
// Assumes: APB answers after a bounded wait; wire pulled up when idle
// Notes:   Expected results queue up; watchers compare as results appear
`timescale 1ns/1ps

module testbench;
    import ledspi_pkg::*;

    localparam logic [32:0] ALL = {33{1'b1}};
    logic        ref_clk;
    logic        arst_n;
    logic        ssn_pin;
    logic        sck_pin;
    logic        mosi_pin;
    logic        miso_out;
    logic        miso_oe;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [15:0] cur_e;
    logic [15:0] cur_m;
    logic [15:0] dm;
    logic [4:0]  a;
    logic [8:0]  d;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          nbad[3] = '{0, 8, 20};
    int unsigned rnd;
    // Open drain: low while enabled, pull-up otherwise
    wire         miso_w = miso_oe ? miso_out : 1'b1;

    ledspi_port dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .ssn_pin(ssn_pin),
        .sck_pin(sck_pin), .mosi_pin(mosi_pin), .miso_out(miso_out), .miso_oe(miso_oe),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ledspi_master master_u (.ssn_pin(ssn_pin), .sck_pin(sck_pin), .mosi_pin(mosi_pin),
        .miso_w(miso_w), .ref_clk(ref_clk));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        num_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic take(input logic [32:0] seen);
        logic [32:0] e;
        logic [32:0] m;
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        if (m !== 33'h0) check(seen & m, e & m);
    endtask : take

    always @(master_u.done_ev) take({17'h0, master_u.rx});
    always @(posedge ref_clk) if (pready === 1'b1 && pwrite == 1'b0) take({pslverr, prdata});

    task automatic print_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                       input logic [32:0] e, input logic [32:0] m);
        int t;
        t = 0;
        if (w == 1'b0) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && t < 50) begin
            t++;
            @(posedge ref_clk);
        end
        if (t == 50) n_mismatch++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reply of this frame is judged in the next one
    task automatic ser(input logic [31:0] w, input int n, input logic [15:0] ne,
                       input logic [15:0] nm);
        // n clocks return the first n bits of reply, then the bits shifted in
        exp_q.push_back({17'h0, 16'({cur_e, w << (32 - n)} >> (48 - n))});
        msk_q.push_back({17'h0, 16'({cur_m, 32'hFFFFFFFF} >> (48 - n))});
        master_u.xfer(w, n);
        cur_e = ne;
        cur_m = nm;
    endtask : ser

    function automatic logic [15:0] fr(input logic c, input logic [4:0] ad,
                                       input logic [8:0] dd, input logic bad);
        return {c, ad, ~^{c, ad, dd} ^ bad, dd};
    endfunction : fr

    function automatic logic [11:0] mem_ofs(input logic [4:0] ad);
        return OFS_MEM + {5'h0, ad, 2'h0};
    endfunction : mem_ofs

    // ------------------------------------------------------------
    // Clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #500000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        arst_n  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        cur_e   = POR_WORD;
        cur_m   = 16'hFFFF;
        rnd     = $urandom(90254);
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        check({32'h0, miso_oe}, 33'h0);
        apb(1'b0, OFS_CTRL, 32'h0, 33'h8, ALL);
        apb(1'b0, 12'h040, 32'h0, {1'b1, 32'h0}, ALL);
        apb(1'b1, OFS_CTRL, 32'h5, 33'h0, 33'h0);
        apb(1'b1, OFS_STAT, 32'hFFFF, 33'h0, 33'h0);
        apb(1'b0, OFS_STAT, 32'h0, 33'h0, 33'h1);
        for (int k = 0; k < 6; k++) begin
            a = 5'($urandom);
            if (a == STATUS_ADDR) a = 5'h2;
            d = 9'($urandom);
            ser(fr(1'b1, a, d, 1'b0), 16, {1'b0, 1'b1, a, d}, 16'hFFFF);
            apb(1'b0, mem_ofs(a), 32'h0, 33'(d), ALL);
            ser(fr(1'b0, a, 9'h0, 1'b0), 16, {1'b0, 2'h3, 4'h5, d}, 16'hFFFF);
        end
        ser(fr(1'b1, a, ~d, 1'b1), 16, POR_WORD, 16'hFFFF);
        ser(fr(1'b0, a, 9'h0, 1'b0), 16, {1'b1, 2'h3, 4'h5, d}, 16'hFFFF);
        apb(1'b0, mem_ofs(a), 32'h0, 33'(d), ALL);
        apb(1'b0, OFS_STAT, 32'h0, 33'h1, 33'h1);
        ser(fr(1'b0, STATUS_ADDR, 9'h0, 1'b0), 16, 16'h8000, 16'h8000);
        ser(fr(1'b0, a, 9'h0, 1'b0), 16, {1'b0, 2'h3, 4'h5, d}, 16'hFFFF);
        foreach (nbad[i]) begin
            ser(32'(fr(1'b0, a, 9'h0, 1'b0)), nbad[i], 16'h8000, 16'h8000);
            ser(fr(1'b0, STATUS_ADDR, 9'h0, 1'b0), 16, 16'h8000, 16'h8000);
            ser(fr(1'b0, a, 9'h0, 1'b0), 16, {1'b0, 2'h3, 4'h5, d}, 16'hFFFF);
        end
        dm = 16'($urandom);
        d  = 9'($urandom);
        // Chained frame: first word shifted in comes back out
        ser({dm, fr(1'b1, a, d, 1'b0)}, 32, {1'b0, 1'b1, a, d}, 16'hFFFF);
        apb(1'b0, mem_ofs(a), 32'h0, 33'(d), ALL);
        ser(fr(1'b0, a, 9'h0, 1'b0), 16, 16'h0, 16'h0);
        print_verdict();
    end

endmodule : testbench
